// ==== inc/phase_timing_pkg.sv ====
// shared constants for the line phase timing and dip detection block
// assumes one 40 MHz clock and a word-wide internal register port
package phase_timing_pkg;

  // ----------------------------------------------------------------
  // clock and tick timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_HZ = 256000;
  localparam int unsigned ACC_STEP_I = TICK_HZ / 1000;
  localparam int unsigned ACC_MOD_I = CLK_HZ / 1000;
  localparam logic [15:0] ACC_STEP = 16'(ACC_STEP_I);
  localparam logic [15:0] ACC_MOD = 16'(ACC_MOD_I);

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int TIME_W = 16;
  localparam int LEVEL_W = 24;
  localparam int COUNT_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PHASES = 3;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PHASE_DELAY_RESULT_0_IDX = 8'h00;
  localparam logic [ADDR_W-1:0] PHASE_DELAY_RESULT_1_IDX = 8'h01;
  localparam logic [ADDR_W-1:0] PHASE_DELAY_RESULT_2_IDX = 8'h02;
  localparam logic [ADDR_W-1:0] LINE_PERIOD_A_IDX = 8'h03;
  localparam logic [ADDR_W-1:0] LINE_PERIOD_B_IDX = 8'h04;
  localparam logic [ADDR_W-1:0] LINE_PERIOD_C_IDX = 8'h05;
  localparam logic [ADDR_W-1:0] DIP_THRESHOLD_IDX = 8'h06;
  localparam logic [ADDR_W-1:0] DIP_HALF_CYCLE_COUNT_IDX = 8'h07;
  localparam logic [ADDR_W-1:0] COMPENSATION_MODE_IDX = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_IDX = 8'h09;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_IDX = 8'h0A;
  localparam logic [ADDR_W-1:0] PER_PHASE_STATUS_IDX = 8'h0B;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DELAY_SEL_LSB = 9;
  localparam int DELAY_SEL_MSB = 10;
  localparam int DIP_FLAG_BIT = 16;
  localparam int DIP_STATE_LSB = 12;
  localparam int DIP_STATE_MSB = 14;
  localparam int COMP_MODE_W = 16;

  // ----------------------------------------------------------------
  // delay group codes
  // ----------------------------------------------------------------
  localparam logic [1:0] GRP_VOLT_CURR = 2'h0;
  localparam logic [1:0] GRP_VOLT_VOLT = 2'h1;
  localparam logic [1:0] GRP_CURR_CURR = 2'h2;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [TIME_W-1:0] TIME_RESET = 16'h0000;
  localparam logic [TIME_W-1:0] TIME_MAX = 16'hFFFF;
  localparam logic [LEVEL_W-1:0] DIP_THRESHOLD_RESET = 24'h000000;
  localparam logic [LEVEL_W-1:0] DIP_LEVEL_NONE = 24'h000001;
  localparam logic [COUNT_W-1:0] DIP_COUNT_RESET = 8'h00;
  localparam logic [COMP_MODE_W-1:0] COMP_MODE_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] IRQ_ENABLE_RESET = 32'h00000000;

endpackage

// ==== rtl/interval_timer.sv ====
// saturating interval timer counting the 256 kHz tick between two events
// assumes start, stop, abort and tick are one-cycle pulses on MCLK
`timescale 1ns/100ps
module interval_timer
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic abort,
  output logic [phase_timing_pkg::TIME_W-1:0] result
);
  import phase_timing_pkg::*;

  typedef struct packed {
    logic running;
    logic [TIME_W-1:0] count;
    logic [TIME_W-1:0] result;
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (s_q.running && tick && (s_q.count != TIME_MAX))
    begin
      s_d.count = s_q.count + 16'h0001;
    end
    if (stop && s_q.running)
    begin
      s_d.result = s_q.count;
      s_d.running = 1'b0;
    end
    if (start)
    begin
      s_d.count = TIME_RESET;
      s_d.running = 1'b1;
    end
    if (abort)
    begin
      s_d.running = 1'b0;
      s_d.count = TIME_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign result = s_q.result;

endmodule

// ==== rtl/line_phase_timing_sag.sv ====
// line phase timing, line period and voltage dip detection
// assumes crossing pulses and absolute samples come from logic on MCLK
//
// Behaviour
// - only rising crossings start or stop delays
// - selector bits 10:9 pick one group
// - selector 00 stores voltage-to-current delay per phase
// - selector 01 stores AC, BC, AB voltage delays
// - selector 10 stores AC, BC, AB current delays
// - delay result is 16-bit 256 kHz count
// - each phase period updated every line period
// - period counts tick between rising voltage crossings
// - 16-bit period reaches down to 3.9 Hz
// - dip flag on sustained below or recovery
// - per-phase dip state set below, cleared above
// - half-cycle count sets flag; zero never programmed
// - enabled flag drives interrupt low same cycle
// - writing flag one clears it, releases interrupt
// - count write with level set restarts counting
// - threshold compared with absolute filtered voltage
// - threshold word carries zero upper byte
// - low-amplitude voltages give no crossing events
`timescale 1ns/100ps
module line_phase_timing_sag
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [phase_timing_pkg::PHASES-1:0] ZX_VOLT_RISE,
  input wire logic [phase_timing_pkg::PHASES-1:0] ZX_CURR_RISE,
  input wire logic [phase_timing_pkg::PHASES-1:0] ZX_VOLT_HALF,
  input wire logic [phase_timing_pkg::PHASES-1:0] VOLT_LOW_AMP,
  input wire logic [phase_timing_pkg::LEVEL_W-1:0] VOLT_ABS_A,
  input wire logic [phase_timing_pkg::LEVEL_W-1:0] VOLT_ABS_B,
  input wire logic [phase_timing_pkg::LEVEL_W-1:0] VOLT_ABS_C,
  input wire logic VOLT_ABS_VALID,
  input wire logic [phase_timing_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [phase_timing_pkg::DATA_W-1:0] REG_WDATA,
  output logic [phase_timing_pkg::DATA_W-1:0] REG_RDATA,
  output logic IRQ_OUT_N
);
  import phase_timing_pkg::*;

  typedef struct packed {
    logic [15:0] acc;
    logic tick;
    logic [COMP_MODE_W-1:0] comp_mode;
    logic [DATA_W-1:0] irq_en;
    logic dip_flag;
    logic irq_n;
    logic [LEVEL_W-1:0] dip_thr;
    logic [COUNT_W-1:0] dip_cnt;
    logic [PHASES-1:0] dip_state;
    logic [PHASES-1:0] hc_below;
    logic [PHASES-1:0] hc_above;
    logic [PHASES-1:0][COUNT_W-1:0] hc_cnt;
    logic [DATA_W-1:0] rdata;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  logic [PHASES-1:0] volt_zx;
  logic [PHASES-1:0] volt_half;
  logic [PHASES-1:0] dly_start;
  logic [PHASES-1:0] dly_stop;
  logic dly_abort;
  logic [PHASES-1:0][TIME_W-1:0] delay_res;
  logic [PHASES-1:0][TIME_W-1:0] period_res;
  logic [PHASES-1:0][LEVEL_W-1:0] volt_abs;
  logic [1:0] grp;
  logic wr_comp;
  logic wr_status;
  logic wr_count;

  // ----------------------------------------------------------------
  // event qualification
  // ----------------------------------------------------------------
  // drop weak voltage crossings
  assign volt_zx = ZX_VOLT_RISE & ~VOLT_LOW_AMP;
  assign volt_half = ZX_VOLT_HALF & ~VOLT_LOW_AMP;
  assign volt_abs = {VOLT_ABS_C, VOLT_ABS_B, VOLT_ABS_A};
  assign grp = s_q.comp_mode[DELAY_SEL_MSB:DELAY_SEL_LSB];
  assign wr_comp = REG_WR && (REG_ADDR == COMPENSATION_MODE_IDX);
  assign wr_status = REG_WR && (REG_ADDR == IRQ_STATUS_IDX);
  assign wr_count = REG_WR && (REG_ADDR == DIP_HALF_CYCLE_COUNT_IDX);
  assign dly_abort = wr_comp
    && (REG_WDATA[DELAY_SEL_MSB:DELAY_SEL_LSB] != grp);

  // ----------------------------------------------------------------
  // delay source selection
  // ----------------------------------------------------------------
  always_comb
  begin
    case (grp)
      GRP_VOLT_VOLT:
      begin
        dly_start = {volt_zx[0], volt_zx[1], volt_zx[0]};
        dly_stop = {volt_zx[1], volt_zx[2], volt_zx[2]};
      end
      GRP_CURR_CURR:
      begin
        dly_start = {ZX_CURR_RISE[0], ZX_CURR_RISE[1], ZX_CURR_RISE[0]};
        dly_stop = {ZX_CURR_RISE[1], ZX_CURR_RISE[2], ZX_CURR_RISE[2]};
      end
      default:
      begin
        dly_start = volt_zx;
        dly_stop = ZX_CURR_RISE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // delay and period timers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PHASES; g++)
    begin : gen_timer
      interval_timer u_delay
      (
        .clk(MCLK),
        .rst_n(RST_N),
        .tick(s_q.tick),
        .start(dly_start[g]),
        .stop(dly_stop[g]),
        .abort(dly_abort),
        .result(delay_res[g])
      );
      interval_timer u_period
      (
        .clk(MCLK),
        .rst_n(RST_N),
        .tick(s_q.tick),
        .start(volt_zx[g]),
        .stop(volt_zx[g]),
        .abort(1'b0),
        .result(period_res[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // tick, dip detection and registers
  // ----------------------------------------------------------------
  always_comb
  begin
    logic below_now;
    logic qualified;
    logic [COUNT_W-1:0] cnt_next;
    logic dip_set;
    below_now = 1'b0;
    qualified = 1'b0;
    cnt_next = '0;
    dip_set = 1'b0;
    s_d = s_q;

    // fractional divider for the 256 kHz tick
    s_d.tick = 1'b0;
    if ((s_q.acc + ACC_STEP) >= ACC_MOD)
    begin
      s_d.acc = s_q.acc + ACC_STEP - ACC_MOD;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.acc = s_q.acc + ACC_STEP;
    end

    for (int p = 0; p < PHASES; p++)
    begin
      below_now = (s_q.dip_thr > DIP_LEVEL_NONE) && (volt_abs[p] < s_q.dip_thr);
      if (VOLT_ABS_VALID)
      begin
        s_d.hc_below[p] = s_q.hc_below[p] & below_now;
        s_d.hc_above[p] = s_q.hc_above[p] & ~below_now;
      end
      if (volt_half[p])
      begin
        qualified = s_q.dip_state[p] ? s_d.hc_above[p] : s_d.hc_below[p];
        cnt_next = s_q.hc_cnt[p] + 8'h01;
        if (qualified && (s_q.dip_cnt != DIP_COUNT_RESET))
        begin
          if (cnt_next == s_q.dip_cnt)
          begin
            s_d.dip_state[p] = ~s_q.dip_state[p];
            s_d.hc_cnt[p] = '0;
            dip_set = 1'b1;
          end
          else
          begin
            s_d.hc_cnt[p] = cnt_next;
          end
        end
        else
        begin
          s_d.hc_cnt[p] = '0;
        end
        s_d.hc_below[p] = 1'b1;
        s_d.hc_above[p] = 1'b1;
      end
    end

    // register writes
    if (REG_WR)
    begin
      case (REG_ADDR)
        DIP_THRESHOLD_IDX:
        begin
          s_d.dip_thr = REG_WDATA[LEVEL_W-1:0];
        end
        DIP_HALF_CYCLE_COUNT_IDX:
        begin
          s_d.dip_cnt = REG_WDATA[COUNT_W-1:0];
        end
        COMPENSATION_MODE_IDX:
        begin
          s_d.comp_mode = REG_WDATA[COMP_MODE_W-1:0];
        end
        IRQ_ENABLE_IDX:
        begin
          s_d.irq_en = REG_WDATA;
        end
        default:
        begin
        end
      endcase
    end

    if (wr_count && (s_q.dip_thr != DIP_THRESHOLD_RESET))
    begin
      s_d.hc_cnt = '0;
      s_d.hc_below = '1;
      s_d.hc_above = '1;
    end

    if (wr_status && REG_WDATA[DIP_FLAG_BIT])
    begin
      s_d.dip_flag = 1'b0;
    end
    if (dip_set)
    begin
      s_d.dip_flag = 1'b1;
    end
    s_d.irq_n = ~(s_d.dip_flag & s_d.irq_en[DIP_FLAG_BIT]);

    // register reads
    s_d.rdata = '0;
    if (REG_RD)
    begin
      case (REG_ADDR)
        PHASE_DELAY_RESULT_0_IDX:
        begin
          s_d.rdata[TIME_W-1:0] = delay_res[0];
        end
        PHASE_DELAY_RESULT_1_IDX:
        begin
          s_d.rdata[TIME_W-1:0] = delay_res[1];
        end
        PHASE_DELAY_RESULT_2_IDX:
        begin
          s_d.rdata[TIME_W-1:0] = delay_res[2];
        end
        LINE_PERIOD_A_IDX:
        begin
          s_d.rdata[TIME_W-1:0] = period_res[0];
        end
        LINE_PERIOD_B_IDX:
        begin
          s_d.rdata[TIME_W-1:0] = period_res[1];
        end
        LINE_PERIOD_C_IDX:
        begin
          s_d.rdata[TIME_W-1:0] = period_res[2];
        end
        DIP_THRESHOLD_IDX:
        begin
          s_d.rdata[LEVEL_W-1:0] = s_q.dip_thr;
        end
        DIP_HALF_CYCLE_COUNT_IDX:
        begin
          s_d.rdata[COUNT_W-1:0] = s_q.dip_cnt;
        end
        COMPENSATION_MODE_IDX:
        begin
          s_d.rdata[COMP_MODE_W-1:0] = s_q.comp_mode;
        end
        IRQ_STATUS_IDX:
        begin
          s_d.rdata[DIP_FLAG_BIT] = s_q.dip_flag;
        end
        IRQ_ENABLE_IDX:
        begin
          s_d.rdata = s_q.irq_en;
        end
        PER_PHASE_STATUS_IDX:
        begin
          s_d.rdata[DIP_STATE_MSB:DIP_STATE_LSB] = s_q.dip_state;
        end
        default:
        begin
          s_d.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      s_q <= '0;
      s_q.comp_mode <= COMP_MODE_RESET;
      s_q.irq_en <= IRQ_ENABLE_RESET;
      s_q.dip_thr <= DIP_THRESHOLD_RESET;
      s_q.dip_cnt <= DIP_COUNT_RESET;
      s_q.irq_n <= 1'b1;
      s_q.hc_below <= '1;
      s_q.hc_above <= '1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA = s_q.rdata;
  assign IRQ_OUT_N = s_q.irq_n;

endmodule

// ==== test/timing_props.sv ====
// concurrent checks on the timing block register port and interrupt
// assumes binding to the block top, one clock domain
`timescale 1ns/100ps
module timing_props
(
  input logic MCLK,
  input logic RST_N,
  input logic [phase_timing_pkg::PHASES-1:0] ZX_VOLT_HALF,
  input logic [phase_timing_pkg::ADDR_W-1:0] REG_ADDR,
  input logic REG_WR,
  input logic REG_RD,
  input logic [phase_timing_pkg::DATA_W-1:0] REG_WDATA,
  input logic [phase_timing_pkg::DATA_W-1:0] REG_RDATA,
  input logic IRQ_OUT_N
);
  import phase_timing_pkg::*;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  logic clr_w;
  logic en_w;
  assign clr_w = REG_WR && REG_ADDR == IRQ_STATUS_IDX;
  assign en_w = REG_WR && REG_ADDR == IRQ_ENABLE_IDX;
  // ----
  // checks
  // ----
  delay_width_a: assert property (
    REG_RD && REG_ADDR <= PHASE_DELAY_RESULT_2_IDX |=> REG_RDATA[31:16] == 16'h0000)
    else $error("delay result wider than 16 bits");
  period_width_a: assert property (
    REG_RD && REG_ADDR inside {[LINE_PERIOD_A_IDX:LINE_PERIOD_C_IDX]}
    |=> REG_RDATA[31:16] == 16'h0000)
    else $error("period result wider than 16 bits");
  thr_pad_a: assert property (
    REG_RD && REG_ADDR == DIP_THRESHOLD_IDX |=> REG_RDATA[31:24] == 8'h00)
    else $error("threshold upper byte not zero");
  cnt_back_a: assert property (
    REG_WR && !REG_RD && REG_ADDR == DIP_HALF_CYCLE_COUNT_IDX
    ##1 REG_RD && !REG_WR && REG_ADDR == DIP_HALF_CYCLE_COUNT_IDX
    |=> REG_RDATA == {24'h000000, $past(REG_WDATA[7:0], 2)})
    else $error("half cycle count readback wrong");
  grp_back_a: assert property (
    REG_WR && !REG_RD && REG_ADDR == COMPENSATION_MODE_IDX
    ##1 REG_RD && !REG_WR && REG_ADDR == COMPENSATION_MODE_IDX
    |=> REG_RDATA[10:9] == $past(REG_WDATA[10:9], 2))
    else $error("group selector readback wrong");
  irq_clear_a: assert property (
    clr_w && REG_WDATA[16] && !(|ZX_VOLT_HALF) && !$past(|ZX_VOLT_HALF) |=> IRQ_OUT_N)
    else $error("interrupt not released by clear");
  irq_fall_a: assert property (
    $fell(IRQ_OUT_N) |-> $past(|ZX_VOLT_HALF) || $past(en_w))
    else $error("interrupt fell without half cycle");
  irq_rise_a: assert property (
    $rose(IRQ_OUT_N) |-> $past(clr_w) || $past(en_w))
    else $error("interrupt rose without write");
  cover property (clr_w && REG_WDATA[16]);
  cover property ($fell(IRQ_OUT_N));
  cover property (REG_RD && REG_ADDR > PER_PHASE_STATUS_IDX);
endmodule
bind line_phase_timing_sag timing_props u_props (.MCLK(MCLK), .RST_N(RST_N),
  .ZX_VOLT_HALF(ZX_VOLT_HALF), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .IRQ_OUT_N(IRQ_OUT_N));

// ==== test/host_model.sv ====
// host side model driving the register port
// assumes each call starts just after a rising clock edge
`timescale 1ns/100ps
module host_model
(
  input logic clk,
  output logic [phase_timing_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [phase_timing_pkg::DATA_W-1:0] reg_wdata,
  input logic [phase_timing_pkg::DATA_W-1:0] reg_rdata
);
  import phase_timing_pkg::*;
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h00000000;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
    @(posedge clk);
  endtask
  task automatic set_dip(input logic [23:0] t, input logic [7:0] c);
    wr(DIP_THRESHOLD_IDX, {8'h00, t});
    @(posedge clk);
    wr(DIP_HALF_CYCLE_COUNT_IDX, {24'h000000, (c == 8'h00) ? 8'h01 : c});
  endtask
  task automatic service(output logic [31:0] st, output logic [31:0] ph);
    rd(IRQ_STATUS_IDX, st);
    rd(PER_PHASE_STATUS_IDX, ph);
    wr(IRQ_STATUS_IDX, 32'h00010000);
  endtask
endmodule

// ==== test/tb.sv ====
// self-checking bench for line timing and dip detection
// assumes the host model makes every register access
`timescale 1ns/100ps
module tb;
  import phase_timing_pkg::*;
  logic mclk, rst_n, valid, wr, rd, irq_n;
  logic [2:0] zx_vr, zx_cr, zx_vh, low_amp;
  logic [23:0] abs_a, abs_b, abs_c;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d, p;
  int n_errors;
  int comparisons;
  line_phase_timing_sag u_dut (.MCLK(mclk), .RST_N(rst_n), .ZX_VOLT_RISE(zx_vr),
    .ZX_CURR_RISE(zx_cr), .ZX_VOLT_HALF(zx_vh), .VOLT_LOW_AMP(low_amp), .VOLT_ABS_A(abs_a),
    .VOLT_ABS_B(abs_b), .VOLT_ABS_C(abs_c), .VOLT_ABS_VALID(valid), .REG_ADDR(addr),
    .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .IRQ_OUT_N(irq_n));
  host_model u_host (.clk(mclk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata));
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp,
    input int tol);
    logic [31:0] df;
    df = (seen > exp) ? seen - exp : exp - seen;
    comparisons++;
    if ($isunknown(seen) || df > 32'(tol))
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic zx(input logic [2:0] v, input logic [2:0] c, input logic [2:0] h);
    zx_vr <= v;
    zx_cr <= c;
    zx_vh <= h;
    @(posedge mclk);
    zx_vr <= 3'h0;
    zx_cr <= 3'h0;
    zx_vh <= 3'h0;
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic t_reset();
    for (int a = 0; a <= 12; a++)
    begin
      u_host.rd(8'(a), d);
      chk("reset read", d, 32'h00000000, 0);
    end
  endtask
  task automatic t_groups();
    logic [2:0] v1[3] = '{3'h7, 3'h1, 3'h0};
    logic [2:0] c1[3] = '{3'h0, 3'h0, 3'h1};
    logic [2:0] v2[3] = '{3'h0, 3'h2, 3'h0};
    logic [2:0] c2[3] = '{3'h1, 3'h0, 3'h2};
    logic [2:0] v3[3] = '{3'h0, 3'h4, 3'h0};
    logic [2:0] c3[3] = '{3'h6, 3'h0, 3'h4};
    int ga[3] = '{10, 10, 20};
    int gb[3] = '{20, 20, 10};
    int ex[3][3] = '{'{10, 30, 30}, '{30, 20, 10}, '{30, 10, 20}};
    for (int g = 0; g < 3; g++)
    begin
      u_host.wr(COMPENSATION_MODE_IDX, 32'(g) << DELAY_SEL_LSB);
      u_host.rd(COMPENSATION_MODE_IDX, d);
      chk("group", {30'h0, d[10:9]}, 32'(g), 0);
      zx(v1[g], c1[g], 3'h0);
      repeat (ga[g] * ACC_MOD_I / ACC_STEP_I) @(posedge mclk);
      zx(v2[g], c2[g], 3'h0);
      repeat (gb[g] * ACC_MOD_I / ACC_STEP_I) @(posedge mclk);
      zx(v3[g], c3[g], 3'h0);
      repeat (2) @(posedge mclk);
      for (int r = 0; r < 3; r++)
      begin
        u_host.rd(PHASE_DELAY_RESULT_0_IDX + 8'(r), d);
        chk("delay", d, 32'(ex[g][r]), 1);
      end
    end
  endtask
  task automatic t_period(input int gap, input logic [2:0] la);
    int ticks;
    ticks = (gap + 1) * ACC_STEP_I / ACC_MOD_I;
    low_amp <= la;
    zx(3'h7, 3'h0, 3'h0);
    repeat (gap) @(posedge mclk);
    zx(3'h7, 3'h0, 3'h0);
    repeat (2) @(posedge mclk);
    for (int k = 0; k < 3; k++)
    begin
      u_host.rd(LINE_PERIOD_A_IDX + 8'(k), d);
      chk("period", d, la[k] ? 32'h00000020 : 32'(ticks), 1);
    end
    low_amp <= 3'h0;
    @(posedge mclk);
  endtask
  task automatic t_dip();
    abs_a <= 24'h000010;
    u_host.wr(IRQ_ENABLE_IDX, 32'h00010000);
    @(posedge mclk);
    u_host.set_dip(24'h000100, 8'h02);
    u_host.rd(DIP_HALF_CYCLE_COUNT_IDX, d);
    chk("count", d, 32'h00000002, 0);
    u_host.rd(DIP_THRESHOLD_IDX, d);
    chk("threshold", d, 32'h00000100, 0);
    for (int i = 1; i <= 2; i++)
    begin
      zx(3'h0, 3'h0, 3'h1);
      @(negedge mclk);
      chk("irq", {31'h0, irq_n}, 32'(i == 1), 0);
      repeat (9) @(posedge mclk);
    end
    u_host.service(d, p);
    chk("status", d, 32'h00010000, 0);
    chk("dip state", p, 32'h00001000, 0);
    @(negedge mclk);
    chk("irq clear", {31'h0, irq_n}, 32'h00000001, 0);
    @(posedge mclk);
    u_host.wr(IRQ_ENABLE_IDX, 32'h00000000);
    abs_a <= 24'h000200;
    repeat (3)
    begin
      repeat (9) @(posedge mclk);
      zx(3'h0, 3'h0, 3'h1);
    end
    u_host.service(d, p);
    chk("status up", d, 32'h00010000, 0);
    chk("dip state up", p, 32'h00000000, 0);
    @(negedge mclk);
    chk("irq masked", {31'h0, irq_n}, 32'h00000001, 0);
    @(posedge mclk);
    abs_a <= 24'h000000;
    u_host.set_dip(24'h000001, 8'h01);
    repeat (2)
    begin
      repeat (9) @(posedge mclk);
      zx(3'h0, 3'h0, 3'h1);
    end
    u_host.service(d, p);
    chk("status none", d, 32'h00000000, 0);
    chk("dip state none", p, 32'h00000000, 0);
  endtask
  // ----
  // run
  // ----
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial
  begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
  initial
  begin
    rst_n = 1'b0;
    zx_vr = 3'h0;
    zx_cr = 3'h0;
    zx_vh = 3'h0;
    low_amp = 3'h0;
    abs_a = 24'h400000;
    abs_b = 24'h400000;
    abs_c = 24'h400000;
    valid = 1'b1;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_groups();
    t_period(4999, 3'h0);
    t_period(1999, 3'h1);
    t_dip();
    complete_run();
  end
endmodule
